// [src/sdcgp_pkg.sv]
// package for the sdram clock-gate, power-down and data-mask block
package sdcgp_pkg;

  // ===================================================================
  // widths
  localparam int DATA_W  = 16;
  localparam int BANKS   = 4;
  localparam int DQM_W   = 2;

  // ===================================================================
  // timing, printed figures and derived cycle counts at 100 MHz
  localparam int CLK_PERIOD_PS            = 10000;
  localparam int INPUT_SETUP_PS           = 1500;
  localparam int POWERDOWN_EXIT_SETUP_TIME_PS = INPUT_SETUP_PS + CLK_PERIOD_PS;
  // least time rounds up
  localparam int PDX_CYC_INT =
    (POWERDOWN_EXIT_SETUP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] PDX_CYC = 4'(PDX_CYC_INT);
  localparam logic [3:0] EXIT_GAP_CYC = 4'h1;

  // ===================================================================
  // commands {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_BST   = 4'h6;

  // reset values
  localparam logic [3:0] BANK_OPEN_RST = 4'h0;

  // ===================================================================
  // carriers
  typedef struct packed {
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [1:0] bank;
  } sdcgp_cmd_t;

  typedef struct packed {
    logic              wr_en;
    logic [DATA_W-1:0] wr_data;
    logic [DQM_W-1:0]  wr_mask;
  } sdcgp_wr_t;

  // gray coded along idle -> active -> suspend; powerdown off idle
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ACTIVE  = 2'b01,
    ST_SUSPEND = 2'b11,
    ST_PWRDN   = 2'b10
  } sdcgp_state_t;

endpackage : sdcgp_pkg

// [src/sdcgp_dqmask.sv]
// per-lane data mask for writes and output enable for reads
`timescale 1ns/1ps
`default_nettype none
module sdcgp_dqmask
  import sdcgp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              hold,
  input  wire logic              bufs_on,
  input  wire logic              rd_active,
  input  wire logic              wr_active,
  input  wire logic [DQM_W-1:0]  dqm,
  input  wire logic [DATA_W-1:0] dq_in,
  output var  sdcgp_wr_t         wr,
  output var  logic [DATA_W-1:0] dq_oe
);

  localparam int LANE = DATA_W / DQM_W;

  // ===================================================================
  // lanes
  genvar g;
  generate
    for (g = 0; g < DQM_W; g++) begin : g_lane
      // read: dqm gates the lane's output buffers, not the data
      always_ff @(posedge clk) begin
        if (srst) begin
          dq_oe[g*LANE +: LANE] <= '0;
        end else if (!hold) begin
          dq_oe[g*LANE +: LANE] <= {LANE{bufs_on & rd_active & ~dqm[g]}};
        end
      end
    end
  endgenerate

  // ===================================================================
  // write path, mask travels with the word
  always_ff @(posedge clk) begin
    if (srst) begin
      wr <= '0;
    end else if (!hold) begin
      // frozen with the internal clock so a suspended burst resumes intact
      wr.wr_en   <= bufs_on & wr_active;
      wr.wr_data <= dq_in;
      wr.wr_mask <= dqm;
    end
  end

endmodule : sdcgp_dqmask
`default_nettype wire

// [src/sdcgp_top.sv]
// clock suspend, power-down and data-mask control inside the sdram
// Operation
// - cke low during a burst masks the internal clock from the next cycle and freezes all state.
// - cke low with all banks idle enters power-down and turns off every buffer except cke.
// - cke high restarts the internal clock the next cycle, with nop or deselect presented.
// - power-down exit re-enables the buffers; the controller allows setup plus one clock.
// - in a write, dqm masks each input word lane so a masked word is not written.
// - in a read, dqm enables or disables the output buffers instead of masking data.
`timescale 1ns/1ps
`default_nettype none
module sdcgp_top
  import sdcgp_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              SRST,
  input  wire logic              CKE,
  input  wire sdcgp_cmd_t        CMD,
  input  wire logic [DQM_W-1:0]  DQM,
  input  wire logic [DATA_W-1:0] DQ_IN,
  input  wire logic              BURST_WR,
  input  wire logic              BURST_RD,
  output var  sdcgp_wr_t         WR,
  output var  logic [DATA_W-1:0] DQ_OE,
  output var  logic              INT_CLK_EN,
  output var  logic              BUFS_ON,
  output var  logic              POWER_DOWN,
  output var  logic              SUSPENDED,
  output var  logic [BANKS-1:0]  BANK_OPEN,
  output var  logic              CMD_ERR
);

  // ===================================================================
  // state
  sdcgp_state_t     state_r;
  sdcgp_state_t     state_nxt;
  logic             cke_q_r;
  logic [3:0]       gap_r;
  logic [BANKS-1:0] bank_open_r;
  logic             rd_burst_r;
  logic             wr_burst_r;
  logic             clk_run;
  logic             in_burst;
  logic             all_idle;
  logic [3:0]       cmd_code;

  assign cmd_code = {CMD.cs_n, CMD.ras_n, CMD.cas_n, CMD.we_n};
  assign in_burst = rd_burst_r | wr_burst_r;
  assign all_idle = (bank_open_r == '0) & ~in_burst;

  // internal clock runs only in idle and active
  assign clk_run  = (state_r == ST_IDLE) | (state_r == ST_ACTIVE);

  // ===================================================================
  // mode fsm
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // a burst flag without an open bank still counts as a burst
        if (!CKE && in_burst) begin
          state_nxt = ST_SUSPEND;
        end else if (!CKE && all_idle) begin
          state_nxt = ST_PWRDN;
        end else if (!all_idle) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!CKE && in_burst) begin
          state_nxt = ST_SUSPEND;
        end else if (!CKE && all_idle) begin
          state_nxt = ST_PWRDN;
        end else if (all_idle) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_SUSPEND: begin
        if (CKE) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_PWRDN: begin
        if (CKE) begin
          state_nxt = (bank_open_r != '0) ? ST_ACTIVE : ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      cke_q_r <= 1'b1;
    end else begin
      cke_q_r <= CKE;
    end
  end

  // ===================================================================
  // exit guard: exit cycle plus one more (two after power-down) must be nop; counts are
  // observed, the device only flags a breach rather than refusing
  always_ff @(posedge CLK) begin
    if (SRST) begin
      gap_r <= 4'h0;
    end else if (!clk_run && CKE) begin
      gap_r <= (state_r == ST_PWRDN) ? PDX_CYC : EXIT_GAP_CYC;
    end else if (gap_r != 4'h0) begin
      gap_r <= gap_r - 4'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      CMD_ERR <= 1'b0;
    end else begin
      // non-nop in the cke-rising cycle or the guard window
      CMD_ERR <= ((!clk_run && CKE) || gap_r != 4'h0) && !CMD.cs_n
                 && cmd_code != CMD_NOP;
    end
  end

  // ===================================================================
  // bank and burst tracking, frozen while the clock is masked
  always_ff @(posedge CLK) begin
    if (SRST) begin
      bank_open_r <= BANK_OPEN_RST;
    end else if (clk_run && cke_q_r && !CMD.cs_n) begin
      if (cmd_code == CMD_ACT) begin
        bank_open_r[CMD.bank] <= 1'b1;
      end else if (cmd_code == CMD_PRE) begin
        bank_open_r[CMD.bank] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rd_burst_r <= 1'b0;
    end else if (clk_run) begin
      rd_burst_r <= BURST_RD;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      wr_burst_r <= 1'b0;
    end else if (clk_run) begin
      wr_burst_r <= BURST_WR;
    end
  end

  // ===================================================================
  // outputs
  always_ff @(posedge CLK) begin
    if (SRST) begin
      INT_CLK_EN <= 1'b1;
    end else begin
      // masked from the cycle after cke low
      INT_CLK_EN <= (state_nxt == ST_IDLE) | (state_nxt == ST_ACTIVE);
    end
  end

  // buffers stay on in suspend, only power-down drops them
  always_ff @(posedge CLK) begin
    if (SRST) begin
      BUFS_ON <= 1'b1;
    end else begin
      BUFS_ON <= state_nxt != ST_PWRDN;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      POWER_DOWN <= 1'b0;
      SUSPENDED  <= 1'b0;
    end else begin
      POWER_DOWN <= state_nxt == ST_PWRDN;
      SUSPENDED  <= state_nxt == ST_SUSPEND;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      BANK_OPEN <= BANK_OPEN_RST;
    end else begin
      BANK_OPEN <= bank_open_r;
    end
  end

  // ===================================================================
  // data mask path
  sdcgp_dqmask i_sdcgp_dqmask (
    .clk       (CLK),
    .srst      (SRST),
    .hold      (~clk_run),
    .bufs_on   (BUFS_ON),
    .rd_active (rd_burst_r & clk_run),
    .wr_active (wr_burst_r & clk_run),
    .dqm       (DQM),
    .dq_in     (DQ_IN),
    .wr        (WR),
    .dq_oe     (DQ_OE)
  );

endmodule : sdcgp_top
`default_nettype wire

// [test/sdcgp_chk.sv]
// assertion checker for the clock gate, power-down and mask block
`timescale 1ns/1ps
`default_nettype none
module sdcgp_chk
  import sdcgp_pkg::*;
(
  input wire logic              CLK,
  input wire logic              SRST,
  input wire logic              CKE,
  input wire logic [DQM_W-1:0]  DQM,
  input wire logic [DATA_W-1:0] DQ_IN,
  input wire sdcgp_wr_t         WR,
  input wire logic [DATA_W-1:0] DQ_OE,
  input wire logic              INT_CLK_EN,
  input wire logic              BUFS_ON,
  input wire logic              POWER_DOWN,
  input wire logic              SUSPENDED,
  input wire logic [BANKS-1:0]  BANK_OPEN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // ==========================================
  // power state
  a_pd_quiet: assert property (POWER_DOWN |-> !BUFS_ON && !INT_CLK_EN && DQ_OE == '0)
    else $error("power-down left a buffer on");
  a_pd_entry: assert property ($rose(POWER_DOWN) |-> !$past(CKE) && $past(BANK_OPEN) == '0)
    else $error("power-down without idle banks");
  a_susp_clk: assert property (SUSPENDED |-> !INT_CLK_EN && BUFS_ON)
    else $error("suspend with clock running");
  a_susp_hold: assert property (SUSPENDED && $past(SUSPENDED) |-> $stable(WR) && $stable(DQ_OE))
    else $error("state moved while suspended");
  a_bank_hold: assert property (SUSPENDED && $past(SUSPENDED) && $past(SUSPENDED, 2) |-> $stable(BANK_OPEN))
    else $error("banks moved while suspended");
  a_wake_up: assert property ((POWER_DOWN || SUSPENDED) && CKE |=> !POWER_DOWN && !SUSPENDED && INT_CLK_EN)
    else $error("no wake one cycle after cke");
  a_pd_exit: assert property ($fell(POWER_DOWN) |-> BUFS_ON)
    else $error("buffers off after exit");
  // ==========================================
  // data lanes
  a_wr_lane: assert property (WR.wr_en && $past(INT_CLK_EN) && !SUSPENDED |-> WR.wr_mask == $past(DQM) && WR.wr_data == $past(DQ_IN))
    else $error("write lane mask wrong");
  a_rd_lane: assert property (DQ_OE != '0 && $past(INT_CLK_EN) && !SUSPENDED |-> DQ_OE == {{8{!$past(DQM[1])}}, {8{!$past(DQM[0])}}})
    else $error("read lane enable wrong");
endmodule : sdcgp_chk
bind sdcgp_top sdcgp_chk i_sdcgp_chk (.*);
`default_nettype wire

// [test/sdcgp_ctrl_model.sv]
// controller model that keeps nop during cke exit and spaces row commands
`timescale 1ns/1ps
`default_nettype none
module sdcgp_ctrl_model
  import sdcgp_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       cke_req,
  input  wire logic       bad,
  input  wire sdcgp_cmd_t cmd_req,
  output var  logic       CKE,
  output var  sdcgp_cmd_t CMD
);
  // slower grade figures in whole clocks, rounded up; one counter each for activate,
  // precharge and write, shared by all banks, stricter than needed but simple
  localparam int TRP_CYC  = (21000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRRD_CYC = (14000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRAS_CYC = (42000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRCD_CYC = (21000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TWR_CYC  = 2;
  logic       cke_q     = 1'b0;
  logic [1:0] gap       = 2'h0;
  logic [2:0] since_act = 3'h7;
  logic [2:0] since_pre = 3'h7;
  logic [2:0] since_wr  = 3'h7;
  logic [3:0] req_code;
  logic [3:0] out_code;
  logic       exit_win;
  logic       act_early;
  logic       pre_early;
  logic       col_early;
  logic       hold_back;
  assign req_code  = {cmd_req.cs_n, cmd_req.ras_n, cmd_req.cas_n, cmd_req.we_n};
  assign out_code  = {CMD.cs_n, CMD.ras_n, CMD.cas_n, CMD.we_n};
  assign exit_win  = (cke_req && !cke_q) || gap != 2'h0;
  assign act_early = since_pre < 3'(TRP_CYC) || since_act < 3'(TRRD_CYC);
  assign pre_early = since_act < 3'(TRAS_CYC) || since_wr < 3'(TWR_CYC);
  assign col_early = since_act < 3'(TRCD_CYC);
  // an early request drops to nop; column commands never wait on each other
  assign hold_back = !cmd_req.cs_n && ((req_code == CMD_ACT && act_early) ||
                     (req_code == CMD_PRE && pre_early) ||
                     ((req_code == CMD_READ || req_code == CMD_WRITE) && col_early));
  // no refresh and no self-refresh is issued: the run is far below a refresh window
  // three nops cover the longer power-down exit guard
  always @(posedge CLK) begin
    cke_q <= cke_req;
    gap   <= (cke_req && !cke_q) ? 2'h3 : ((gap != 2'h0) ? gap - 2'h1 : gap);
  end
  // counters saturate at seven and start at one on the edge taking the command
  always @(posedge CLK) begin
    since_act <= (!CMD.cs_n && out_code == CMD_ACT) ? 3'h1 :
                 ((since_act != 3'h7) ? since_act + 3'h1 : since_act);
    since_pre <= (!CMD.cs_n && out_code == CMD_PRE) ? 3'h1 :
                 ((since_pre != 3'h7) ? since_pre + 3'h1 : since_pre);
    since_wr  <= (!CMD.cs_n && out_code == CMD_WRITE) ? 3'h1 :
                 ((since_wr != 3'h7) ? since_wr + 3'h1 : since_wr);
  end
  assign CKE = cke_req;
  assign CMD = ((!bad && exit_win) || hold_back) ? {CMD_NOP, cmd_req.bank} : cmd_req;
endmodule : sdcgp_ctrl_model
`default_nettype wire

// [test/sdram_clock_gate_power_timing_test.sv]
// self-checking bench for the clock gate, power-down and mask block
`timescale 1ns/1ps
`default_nettype none
module sdram_clock_gate_power_timing_test import sdcgp_pkg::*;;
  logic              clk = 1'b0, srst = 1'b1, cke_req = 1'b1, bad = 1'b0, brd = 1'b0, bwr = 1'b0;
  logic [DQM_W-1:0]  dqm = 2'h0;
  logic [DATA_W-1:0] dq = 16'h0000, oe;
  sdcgp_cmd_t        cmd_req = {CMD_NOP, 2'h0}, cmd;
  sdcgp_wr_t         wr;
  logic              cke, clk_en, bufs, pd, susp, err;
  logic [BANKS-1:0]  banks;
  int                fail_count = 0, checked = 0, cyc = 0;
  sdcgp_ctrl_model i_sdcgp_ctrl_model (.CLK(clk), .cke_req(cke_req), .bad(bad),
    .cmd_req(cmd_req), .CKE(cke), .CMD(cmd));
  sdcgp_top i_sdcgp_top (.CLK(clk), .SRST(srst), .CKE(cke), .CMD(cmd), .DQM(dqm), .DQ_IN(dq),
    .BURST_WR(bwr), .BURST_RD(brd), .WR(wr), .DQ_OE(oe), .INT_CLK_EN(clk_en), .BUFS_ON(bufs),
    .POWER_DOWN(pd), .SUSPENDED(susp), .BANK_OPEN(banks), .CMD_ERR(err));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic t_pd;
    cke_req = 1'b0;
    step(1);
    chk({clk_en, bufs, pd, oe}, {3'b001, 16'h0000});
    cke_req = 1'b1;
    cmd_req = {CMD_ACT, 2'h1};
    step(1);
    chk({clk_en, bufs, pd}, 3'b110);
    step(3);
    cmd_req = {CMD_NOP, 2'h0};
    chk({err, banks}, 5'h00);
    bad = 1'b1;
    cke_req = 1'b0;
    step(1);
    cke_req = 1'b1;
    cmd_req = {CMD_ACT, 2'h1};
    step(1);
    cmd_req = {CMD_NOP, 2'h0};
    bad = 1'b0;
    chk({err, banks}, 5'h10);
    step(3);
    $display("power-down test done");
  endtask : t_pd
  task automatic t_susp;
    brd = 1'b1;
    step(2);
    chk(oe, 16'hffff);
    cke_req = 1'b0;
    step(1);
    chk({clk_en, bufs, susp}, 3'b011);
    dqm = 2'h3;
    step(2);
    chk(oe, 16'hffff);
    cke_req = 1'b1;
    step(1);
    chk({clk_en, susp}, 2'b10);
    step(1);
    chk(oe, 16'h0000);
    dqm = 2'h1;
    step(1);
    chk(oe, 16'hff00);
    brd = 1'b0;
    step(3);
    $display("suspend test done");
  endtask : t_susp
  task automatic t_wr;
    bwr = 1'b1;
    step(1);
    for (int i = 0; i < 4; i++) begin
      dqm = 2'(i);
      dq = 16'h5a5a ^ 16'(i);
      step(1);
      chk(wr, {1'b1, dq, dqm});
    end
    bwr = 1'b0;
    step(3);
    chk(oe, 16'h0000);
    $display("write mask test done");
  endtask : t_wr
  task automatic t_bank;
    cmd_req = {CMD_ACT, 2'h2};
    step(1);
    cmd_req = {CMD_NOP, 2'h0};
    step(1);
    chk(banks, 4'h4);
    cke_req = 1'b0;
    step(1);
    chk({clk_en, bufs, pd, susp}, 4'b1100);
    cke_req = 1'b1;
    step(4);
    cmd_req = {CMD_PRE, 2'h2};
    step(1);
    cmd_req = {CMD_ACT, 2'h1};
    step(1);
    cmd_req = {CMD_NOP, 2'h0};
    step(1);
    chk({err, banks}, 5'h00);
    $display("bank test done");
  endtask : t_bank
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #1;
    srst = 1'b0;
    chk({clk_en, bufs, pd, susp, err, banks, oe}, {9'h180, 16'h0000});
    $display("reset test done");
    t_pd();
    t_susp();
    t_wr();
    t_bank();
    stop_test();
  end
endmodule : sdram_clock_gate_power_timing_test
`default_nettype wire
